// ==== core/lin_flags_map.vh ====
// Constants for the third/fourth LIN channel diagnostic flag register
`ifndef LIN_FLAGS_MAP_VH
`define LIN_FLAGS_MAP_VH

`define CMD_DIAG_FLAGS 8'h8d
`define CMD_BITS 6'd8
`define FRAME_BITS 6'd32
`define DATA_BITS 6'd16
`define FRAME_LAST 6'd31
`define CNT_MAX 6'h3f

`define FLAGS_RESET 16'h0000
`define NUM_CH 2
`define CH_STRIDE 8
`define POS_BUSDOM 0
`define POS_TXDOM 1
`define POS_RXHIGH 2
`define POS_RXLOW 3
`define POS_TEMP 4
`define POS_UNUSED_LO 5
`define POS_WAKE 6
`define POS_UNUSED_HI 7

`define SYNC_WIDTH 15
`define SYNC_RESET 15'h4000
`define SYNC_CS 14
`define SYNC_SCLK 13
`define SYNC_MOSI 12
`define SYNC_BUSDOM 10
`define SYNC_TXDOM 8
`define SYNC_RXHIGH 6
`define SYNC_RXLOW 4
`define SYNC_TEMP 2
`define SYNC_WAKE 0

`endif

// ==== core/pin_sync3.v ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk_sys,
    input wire nrst,
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] pinOut
);
    reg [WIDTH-1:0] stage1_r;
    reg [WIDTH-1:0] stage2_r;
    reg [WIDTH-1:0] stage3_r;
    genvar i;

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_r <= RESET_VAL;
            stage2_r <= RESET_VAL;
            stage3_r <= RESET_VAL;
        end
        else
        begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // A new level counts only once stages two and three agree
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : gBit
            always @(posedge clk_sys or negedge nrst)
            begin
                if (!nrst)
                    pinOut[i] <= RESET_VAL[i];
                else if (stage2_r[i] == stage3_r[i])
                    pinOut[i] <= stage3_r[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== core/lin_pair_diag_flags.v ====
// Diagnostic flag register for LIN channels three and four, read over SPI
`timescale 1ns/1ps
`default_nettype none
`include "lin_flags_map.vh"
module lin_pair_diag_flags (
    input wire clk_sys,
    input wire nrst,
    input wire spiSclk,
    input wire spiMosi,
    input wire spiCsN,
    input wire [1:0] wakeSrc,
    input wire [1:0] overTemp,
    input wire [1:0] rxStuckLow,
    input wire [1:0] rxStuckHigh,
    input wire [1:0] txStuckDom,
    input wire [1:0] busDomTimeout,
    output reg misoOut,
    output reg misoOe
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    wire [`SYNC_WIDTH-1:0] syncOut;
    wire csN;
    wire sclk;
    wire mosi;
    wire [1:0] wakeS;
    wire [1:0] tempS;
    wire [1:0] rxLowS;
    wire [1:0] rxHighS;
    wire [1:0] txDomS;
    wire [1:0] busDomS;

    pin_sync3 #(
        .WIDTH(`SYNC_WIDTH),
        .RESET_VAL(`SYNC_RESET)
    ) uSync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        // Order must match the SYNC_ positions, top bit first
        .pinIn({
            spiCsN,
            spiSclk,
            spiMosi,
            busDomTimeout,
            txStuckDom,
            rxStuckHigh,
            rxStuckLow,
            overTemp,
            wakeSrc
        }),
        .pinOut(syncOut)
    );

    assign csN = syncOut[`SYNC_CS];
    assign sclk = syncOut[`SYNC_SCLK];
    assign mosi = syncOut[`SYNC_MOSI];
    assign busDomS = syncOut[`SYNC_BUSDOM +: `NUM_CH];
    assign txDomS = syncOut[`SYNC_TXDOM +: `NUM_CH];
    assign rxHighS = syncOut[`SYNC_RXHIGH +: `NUM_CH];
    assign rxLowS = syncOut[`SYNC_RXLOW +: `NUM_CH];
    assign tempS = syncOut[`SYNC_TEMP +: `NUM_CH];
    assign wakeS = syncOut[`SYNC_WAKE +: `NUM_CH];

    ////////////////////////////////////////////////////////////////////////
    // SPI frame tracking

    reg sclkPrev_r;
    reg csPrev_r;
    reg [5:0] bitCnt_r;
    reg [7:0] cmd_r;
    reg hit_r;
    reg [15:0] snap_r;
    reg [15:0] flags_r;
    wire [15:0] flagsNxt;
    wire [7:0] cmdNxt;
    wire sclkRise;
    wire sclkFall;
    wire frameEnd;
    wire readClr;
    wire [5:0] outIdx;

    assign sclkRise = sclk & ~sclkPrev_r & ~csN;
    assign sclkFall = ~sclk & sclkPrev_r & ~csN;
    assign frameEnd = csN & ~csPrev_r;
    assign cmdNxt = {cmd_r[6:0], mosi};
    assign outIdx = `FRAME_LAST - bitCnt_r;
    // Only a complete frame that selected this register clears flags
    assign readClr = frameEnd & hit_r & (bitCnt_r == `FRAME_BITS);

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sclkPrev_r <= 1'b0;
            csPrev_r <= 1'b1;
            bitCnt_r <= 6'h00;
            cmd_r <= 8'h00;
            hit_r <= 1'b0;
            snap_r <= `FLAGS_RESET;
        end
        else
        begin
            sclkPrev_r <= sclk;
            csPrev_r <= csN;
            if (csN)
            begin
                bitCnt_r <= 6'h00;
                hit_r <= 1'b0;
            end
            else if (sclkRise)
            begin
                cmd_r <= cmdNxt;
                if (bitCnt_r != `CNT_MAX)
                    bitCnt_r <= bitCnt_r + 6'h01;
                // Command byte complete: capture the flags to be returned
                if (bitCnt_r == `CMD_BITS - 6'h01 &&
                    cmdNxt == `CMD_DIAG_FLAGS)
                begin
                    hit_r <= 1'b1;
                    snap_r <= flags_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // MISO shifting, MSB first, changed on falling clock edges

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            misoOut <= 1'b0;
            misoOe <= 1'b0;
        end
        else
        begin
            misoOe <= ~csN;
            if (csN)
                misoOut <= 1'b0;
            else if (sclkFall)
            begin
                if (hit_r && bitCnt_r >= `DATA_BITS &&
                    bitCnt_r < `FRAME_BITS)
                    misoOut <= snap_r[outIdx[3:0]];
                else
                    misoOut <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag latches

    // Set wins over a clear that arrives in the same cycle
    function flagNext;
        input cur;
        input cond;
        input clr;
        begin
            flagNext = cond | (cur & ~clr);
        end
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CH; ch = ch + 1)
        begin : gCh
            localparam integer B = ch * `CH_STRIDE;
            assign flagsNxt[B + `POS_WAKE] = flagNext(flags_r[B + `POS_WAKE],
                wakeS[ch], readClr & snap_r[B + `POS_WAKE]);
            assign flagsNxt[B + `POS_TEMP] = flagNext(flags_r[B + `POS_TEMP],
                tempS[ch], readClr & snap_r[B + `POS_TEMP]);
            assign flagsNxt[B + `POS_RXLOW] = flagNext(
                flags_r[B + `POS_RXLOW], rxLowS[ch],
                readClr & snap_r[B + `POS_RXLOW]);
            assign flagsNxt[B + `POS_RXHIGH] = flagNext(
                flags_r[B + `POS_RXHIGH], rxHighS[ch],
                readClr & snap_r[B + `POS_RXHIGH]);
            assign flagsNxt[B + `POS_TXDOM] = flagNext(
                flags_r[B + `POS_TXDOM], txDomS[ch],
                readClr & snap_r[B + `POS_TXDOM]);
            assign flagsNxt[B + `POS_BUSDOM] = flagNext(
                flags_r[B + `POS_BUSDOM], busDomS[ch],
                readClr & snap_r[B + `POS_BUSDOM]);
            assign flagsNxt[B + `POS_UNUSED_LO] = 1'b0;
            assign flagsNxt[B + `POS_UNUSED_HI] = 1'b0;
        end
    endgenerate

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            flags_r <= `FLAGS_RESET;
        else
            flags_r <= flagsNxt;
    end
endmodule
`default_nettype wire

// ==== tb/lin_pair_diag_flags_sva.sv ====
// Pin-level checks on the flag register's SPI port
`timescale 1ns/1ps
`default_nettype none
module lin_flags_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic misoOut,
    input wire logic misoOe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_OE_OFF: assert property (spiCsN [*8] |-> !misoOe)
        else $error("enable while deselected");
    AST_OE_ON: assert property (!spiCsN [*8] |-> misoOe)
        else $error("no enable in frame");
    AST_QUIET: assert property (!misoOe |-> !misoOut)
        else $error("data while disabled");
    AST_OE_RISE: assert property ($fell(spiCsN) |-> ##[2:8] misoOe)
        else $error("enable late");
    AST_OE_FALL: assert property ($rose(spiCsN) |-> ##[2:8] !misoOe)
        else $error("release late");
    AST_HOLD: assert property (
        (spiSclk && !spiCsN) [*3] |-> $stable(misoOut))
        else $error("data moved on high clock");
    AST_CAUSE: assert property ($rose(misoOe) |-> !$past(spiCsN, 2))
        else $error("enable without select");
    AST_DROP: assert property ($fell(misoOe) |-> $past(spiCsN, 2))
        else $error("release without deselect");
    COV_FRAME: cover property ($rose(misoOe));
    COV_ONE: cover property (misoOe && misoOut);
    COV_END: cover property ($fell(misoOe));
endmodule
bind lin_pair_diag_flags lin_flags_checker chk (.clk_sys(clk_sys),
    .nrst(nrst), .spiSclk(spiSclk), .spiCsN(spiCsN), .misoOut(misoOut),
    .misoOe(misoOe));
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// SPI host that reads the flag register, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk_sys,
    input wire logic misoIn,
    output var logic spiSclk,
    output var logic spiMosi,
    output var logic spiCsN
);
    initial
    begin
        spiSclk = 1'b0;
        spiMosi = 1'b0;
        spiCsN = 1'b1;
    end
    task automatic xfer(input logic [7:0] cmd, input int n,
        output logic [31:0] rx);
        logic [31:0] tx;
        tx = {cmd, 24'h000000};
        rx = 32'h00000000;
        spiCsN <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spiMosi <= tx[31 - i];
            repeat (7) @(posedge clk_sys);
            spiSclk <= 1'b1;
            rx = {rx[30:0], misoIn};
            repeat (7) @(posedge clk_sys);
            spiSclk <= 1'b0;
        end
        repeat (7) @(posedge clk_sys);
        spiCsN <= 1'b1;
        // Released data line must not keep its last value
        spiMosi <= ~spiMosi;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the channel three/four flag register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    logic clk_sys, nrst, spiSclk, spiMosi, spiCsN, misoOut, misoOe;
    logic [11:0] cause;
    logic [31:0] rx;
    int failures = 0, comparisons = 0, cycles = 0;
    lin_pair_diag_flags uut (.clk_sys(clk_sys), .nrst(nrst),
        .spiSclk(spiSclk), .spiMosi(spiMosi), .spiCsN(spiCsN),
        .wakeSrc(cause[11:10]), .overTemp(cause[9:8]),
        .rxStuckLow(cause[7:6]), .rxStuckHigh(cause[5:4]),
        .txStuckDom(cause[3:2]), .busDomTimeout(cause[1:0]),
        .misoOut(misoOut), .misoOe(misoOe));
    spi_host_model host (.clk_sys(clk_sys), .misoIn(misoOut),
        .spiSclk(spiSclk), .spiMosi(spiMosi), .spiCsN(spiCsN));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            test_done;
        end
    end
    task test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task rd(input logic [7:0] cmd, input logic [15:0] e);
        host.xfer(cmd, 32, rx);
        `CHK("reply", {16'h0000, e}, rx)
        `CHK("oe", 1'b0, misoOe)
    endtask
    task t_reset;
        rd(8'h8d, 16'h0000);
        cause <= 12'hfff;
        wt(10);
        rd(8'h8c, 16'h0000);
        rd(8'h8d, 16'h5f5f);
        cause <= 12'h000;
        wt(10);
        nrst <= 1'b0;
        wt(3);
        nrst <= 1'b1;
        wt(2);
        `CHK("idle", 2'b00, {misoOe, misoOut})
        rd(8'h8d, 16'h0000);
    endtask
    task t_latch;
        logic [15:0] e;
        for (int j = 0; j < 12; j++)
        begin
            e = 16'h0001 << ((j / 2 == 5 ? 6 : j / 2) + 8 * (j % 2));
            cause[j] <= 1'b1;
            wt(10);
            rd(8'h8d, e);
            rd(8'h8d, e);
            cause[j] <= 1'b0;
            wt(10);
            rd(8'h8d, e);
            rd(8'h8d, 16'h0000);
        end
    endtask
    task t_refuse;
        cause[8] <= 1'b1;
        wt(10);
        cause[8] <= 1'b0;
        wt(10);
        host.xfer(8'h8d, 31, rx);
        rd(8'h8c, 16'h0000);
        rd(8'h8d, 16'h0010);
        rd(8'h8d, 16'h0000);
    endtask
    initial
    begin
        nrst = 1'b0;
        cause = 12'h000;
        wt(5);
        nrst <= 1'b1;
        wt(2);
        t_reset;
        t_latch;
        t_refuse;
        test_done;
    end
endmodule
`default_nettype wire
